// ==== include/ssq_pkg.sv ====
// Constants, register map and carrier types of the step/direction sequencer
package ssq_pkg;

    localparam int          SSQ_CLK_HZ        = 20_000_000;
    localparam int          SSQ_POS_W         = 10;
    localparam int          SSQ_CNT_W         = 21;
    localparam int          SSQ_ADDR_W        = 4;

    // Register word addresses
    localparam logic [3:0]  SSQ_ADDR_CHOP     = 4'h0;
    localparam logic [3:0]  SSQ_ADDR_SCALE    = 4'h1;
    localparam logic [3:0]  SSQ_ADDR_STAT     = 4'h2;
    localparam logic [3:0]  SSQ_ADDR_INTV     = 4'h3;

    // Chopper configuration fields
    localparam int          SSQ_CHOP_RES_LSB  = 0;
    localparam int          SSQ_CHOP_DEDGE    = 4;
    localparam int          SSQ_CHOP_INTPOL   = 5;
    localparam int          SSQ_CHOP_EXTSTEP  = 6;
    localparam logic [3:0]  SSQ_RES_RST       = 4'h0;
    localparam logic [3:0]  SSQ_RES_MAX       = 4'h8;
    localparam logic        SSQ_DEDGE_RST     = 1'b0;
    localparam logic        SSQ_INTPOL_RST    = 1'b0;
    localparam logic        SSQ_EXTSTEP_RST   = 1'b1;

    // Current scale fields
    localparam int          SSQ_HOLD_LSB      = 0;
    localparam int          SSQ_RUN_LSB       = 8;
    localparam logic [4:0]  SSQ_HOLD_RST      = 5'h08;
    localparam logic [4:0]  SSQ_RUN_RST       = 5'h1f;

    // Status fields
    localparam int          SSQ_STAT_POS_LSB  = 0;
    localparam int          SSQ_STAT_STST     = 16;
    localparam int          SSQ_STAT_BURST    = 17;
    localparam logic        SSQ_STST_RST      = 1'b1;
    localparam logic [9:0]  SSQ_POS_RST       = 10'h000;

    // Standstill interval limit in system clock cycles
    localparam logic [20:0] SSQ_STST_LIMIT    = 21'h100000;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ssq_bus_req_t;

    typedef struct packed {
        logic        stst;
        logic        burst;
        logic [9:0]  pos;
        logic [4:0]  scale;
    } ssq_motor_t;

    typedef enum logic [1:0] {
        SSQ_ST_IDLE  = 2'b01,
        SSQ_ST_BURST = 2'b10
    } ssq_state_t;

endpackage : ssq_pkg

// ==== src/ssq_step_dir_sequencer.sv ====
// Step/direction microstep sequencer with interpolator and standstill detection
//
// Summary of operation
// (R1) Both-edge mode: every step transition counts
// (R2) Single-edge mode: only rising step transitions count
// (R3) Step and direction synchronised to system clock
// (R4) Controller limits step rate to clock fraction
// (R5) Position indexes 1024-entry table, four full steps
// (R6) Direction low adds width, high subtracts
// (R7) Width doubles per coarser setting, 1 to 256
// (R8) Coarser resolution snaps to nearest valid step
// (R9) Full steps visit 128, 384, 640, 896
// (R10) Valid positions sit half a width above zero
// (R11) Interpolation spreads each step evenly over interval
// (R12) Dedicated chopper configuration bit enables interpolation
// (R13) Microstep period is interval over step width
// (R14) Interval above limit sets standstill flag
// (R15) Standstill switches current scale to hold value
// (R16) Next active step clears standstill flag
// (R17) New timing adopted after one measured interval
// (R18) Controller uses both edges only at even duty
// (R19) External stepping keeps only current scale settings
// (R20) Position is ten bits, wraps both ways
// (R21) Resolution is power of two, clamped at 256
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module ssq_step_dir_sequencer #(
    parameter logic [20:0] STST_LIMIT = ssq_pkg::SSQ_STST_LIMIT
) (
    input  wire logic                 clk_sys,
    input  wire logic                 resetn,
    input  wire logic                 step_in,
    input  wire logic                 dir_in,
    input  wire ssq_pkg::ssq_bus_req_t bus_req,
    output logic [31:0]               bus_rdata,
    output ssq_pkg::ssq_motor_t       motor
);
    import ssq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [3:0]            res_reg;
    logic                  dedge_reg;
    logic                  intpol_reg;
    logic                  extstep_reg;
    logic [4:0]            hold_reg;
    logic [4:0]            run_reg;
    logic [31:0]           rdata_reg;
    logic [31:0]           rdata_next;

    logic [2:0]            step_sync_reg;
    logic [2:0]            dir_sync_reg;
    logic                  step_lvl_reg;
    logic                  step_prev_reg;
    logic                  dir_lvl_reg;
    logic                  step_rise;
    logic                  step_fall;
    logic                  step_evt;

    logic [3:0]            sh;
    logic [3:0]            sh_prev_reg;
    logic                  coarser;
    logic [9:0]            width;
    logic [9:0]            mask;
    logic [9:0]            half;
    logic [9:0]            snapped;

    logic [SSQ_CNT_W-1:0]  intv_cnt_reg;
    logic [SSQ_CNT_W-1:0]  intv_reg;
    logic                  limit_hit;
    logic                  stst_set;
    logic                  stst_reg;

    ssq_state_t            state_reg;
    ssq_state_t            state_next;
    logic [9:0]            pos_reg;
    logic [9:0]            pos_next;
    logic [9:0]            target_reg;
    logic [9:0]            target_next;
    logic [9:0]            base;
    logic                  bdir_reg;
    logic [8:0]            remain_reg;
    logic [8:0]            remain_next;
    logic [SSQ_CNT_W-1:0]  tick_per_reg;
    logic [SSQ_CNT_W-1:0]  tick_per_next;
    logic [SSQ_CNT_W-1:0]  tick_cnt_reg;
    logic [SSQ_CNT_W-1:0]  tick_cnt_next;
    logic [SSQ_CNT_W-1:0]  per_calc;
    logic                  micro_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus

    // Chopper configuration
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            res_reg     <= SSQ_RES_RST;
            dedge_reg   <= SSQ_DEDGE_RST;
            intpol_reg  <= SSQ_INTPOL_RST;
            extstep_reg <= SSQ_EXTSTEP_RST;
        end else if (bus_req.wr && bus_req.addr == SSQ_ADDR_CHOP) begin
            res_reg     <= bus_req.wdata[SSQ_CHOP_RES_LSB +: 4];
            dedge_reg   <= bus_req.wdata[SSQ_CHOP_DEDGE];
            intpol_reg  <= bus_req.wdata[SSQ_CHOP_INTPOL]; // R12
            extstep_reg <= bus_req.wdata[SSQ_CHOP_EXTSTEP];
        end
    end

    // Current scale settings
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hold_reg <= SSQ_HOLD_RST;
            run_reg  <= SSQ_RUN_RST;
        end else if (bus_req.wr && bus_req.addr == SSQ_ADDR_SCALE) begin
            hold_reg <= bus_req.wdata[SSQ_HOLD_LSB +: 5];
            run_reg  <= bus_req.wdata[SSQ_RUN_LSB +: 5];
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                SSQ_ADDR_CHOP: begin
                    rdata_next[SSQ_CHOP_RES_LSB +: 4] = res_reg;
                    rdata_next[SSQ_CHOP_DEDGE]        = dedge_reg;
                    rdata_next[SSQ_CHOP_INTPOL]       = intpol_reg;
                    rdata_next[SSQ_CHOP_EXTSTEP]      = extstep_reg;
                end
                SSQ_ADDR_SCALE: begin
                    rdata_next[SSQ_HOLD_LSB +: 5] = hold_reg;
                    rdata_next[SSQ_RUN_LSB +: 5]  = run_reg;
                end
                SSQ_ADDR_STAT: begin
                    rdata_next[SSQ_STAT_POS_LSB +: 10] = pos_reg;
                    rdata_next[SSQ_STAT_STST]          = stst_reg;
                    rdata_next[SSQ_STAT_BURST]         = (state_reg == SSQ_ST_BURST);
                end
                SSQ_ADDR_INTV: begin
                    rdata_next[SSQ_CNT_W-1:0] = intv_reg;
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    // Read data registered, zero when no read
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign bus_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and edge detection

    // Three-stage synchronisers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            step_sync_reg <= 3'h0;
            dir_sync_reg  <= 3'h0;
        end else begin
            step_sync_reg <= {step_sync_reg[1:0], step_in}; // R3
            dir_sync_reg  <= {dir_sync_reg[1:0], dir_in}; // R3
        end
    end

    // Level accepted once stages two and three agree
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            step_lvl_reg  <= 1'b0;
            step_prev_reg <= 1'b0;
            dir_lvl_reg   <= 1'b0;
        end else begin
            if (step_sync_reg[1] == step_sync_reg[2]) begin
                step_lvl_reg <= step_sync_reg[2];
            end
            if (dir_sync_reg[1] == dir_sync_reg[2]) begin
                dir_lvl_reg <= dir_sync_reg[2];
            end
            step_prev_reg <= step_lvl_reg;
        end
    end

    assign step_rise = step_lvl_reg & ~step_prev_reg; // R2
    assign step_fall = ~step_lvl_reg & step_prev_reg;
    assign step_evt  = extstep_reg & (step_rise | (dedge_reg & step_fall)); // R1

    ////////////////////////////////////////////////////////////////////////////
    // Resolution decode and snapping

    assign sh      = (res_reg > SSQ_RES_MAX) ? SSQ_RES_MAX : res_reg; // R21
    assign width   = 10'h001 << sh; // R7
    assign mask    = width - 10'h001;
    assign half    = width >> 1; // R10
    assign snapped = (pos_reg & ~mask) | half; // R8
    assign coarser = (sh > sh_prev_reg);

    // Previous resolution for snap detection
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sh_prev_reg <= SSQ_RES_RST;
        end else begin
            sh_prev_reg <= sh;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interval measurement and standstill

    assign limit_hit = (intv_cnt_reg == STST_LIMIT);

    // One-shot set as the count arrives at the limit, so a saturated
    // count cannot override the step event that clears the flag
    assign stst_set  = !step_evt && !limit_hit && (intv_cnt_reg == STST_LIMIT - 21'h000001);

    // Interval counter saturates at the limit
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            intv_cnt_reg <= {SSQ_CNT_W{1'b0}};
            intv_reg     <= {SSQ_CNT_W{1'b0}};
        end else if (step_evt) begin
            intv_cnt_reg <= {{(SSQ_CNT_W-1){1'b0}}, 1'b1};
            intv_reg     <= intv_cnt_reg; // R17
        end else if (!limit_hit) begin
            intv_cnt_reg <= intv_cnt_reg + {{(SSQ_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stst_reg <= SSQ_STST_RST;
        end else if (stst_set) begin
            stst_reg <= 1'b1; // R14
        end else if (step_evt) begin
            stst_reg <= 1'b0; // R16
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Microstep sequencer and interpolator

    assign per_calc   = intv_cnt_reg >> sh; // R13
    assign micro_tick = (state_reg == SSQ_ST_BURST) && (tick_cnt_reg == tick_per_reg);
    assign base       = (state_reg == SSQ_ST_BURST) ? target_reg : pos_reg; // R17

    always_comb begin
        state_next    = state_reg;
        pos_next      = pos_reg;
        target_next   = target_reg;
        remain_next   = remain_reg;
        tick_per_next = tick_per_reg;
        tick_cnt_next = tick_cnt_reg;
        if (coarser) begin
            pos_next    = snapped; // R8
            target_next = snapped;
            state_next  = SSQ_ST_IDLE;
        end else if (step_evt) begin
            target_next = dir_lvl_reg ? base - width : base + width; // R6
            if (intpol_reg && !stst_reg && sh != 4'h0) begin
                pos_next      = base; // R17
                remain_next   = {1'b0, width[7:0]} | {sh == SSQ_RES_MAX, 8'h00};
                tick_per_next = (per_calc == {SSQ_CNT_W{1'b0}})
                              ? {{(SSQ_CNT_W-1){1'b0}}, 1'b1} : per_calc;
                tick_cnt_next = {{(SSQ_CNT_W-1){1'b0}}, 1'b1};
                state_next    = SSQ_ST_BURST; // R11
            end else begin
                pos_next   = dir_lvl_reg ? base - width : base + width; // R20
                state_next = SSQ_ST_IDLE;
            end
        end else if (state_reg == SSQ_ST_BURST) begin
            if (micro_tick) begin
                pos_next      = bdir_reg ? pos_reg - 10'h001 : pos_reg + 10'h001; // R11
                remain_next   = remain_reg - 9'h001;
                tick_cnt_next = {{(SSQ_CNT_W-1){1'b0}}, 1'b1};
                if (remain_reg == 9'h001) begin
                    state_next = SSQ_ST_IDLE;
                end
            end else begin
                tick_cnt_next = tick_cnt_reg + {{(SSQ_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Sequencer state
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= SSQ_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Position and burst target
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pos_reg    <= SSQ_POS_RST; // R5
            target_reg <= SSQ_POS_RST;
        end else begin
            pos_reg    <= pos_next; // R9
            target_reg <= target_next;
        end
    end

    // Burst direction, count and microstep timer
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bdir_reg     <= 1'b0;
            remain_reg   <= 9'h000;
            tick_per_reg <= {{(SSQ_CNT_W-1){1'b0}}, 1'b1};
            tick_cnt_reg <= {{(SSQ_CNT_W-1){1'b0}}, 1'b1};
        end else begin
            if (step_evt) begin
                bdir_reg <= dir_lvl_reg;
            end
            remain_reg   <= remain_next;
            tick_per_reg <= tick_per_next;
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Motor outputs

    // Registered copies of the internal state
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            motor <= '0;
        end else begin
            motor.stst  <= stst_reg;
            motor.burst <= (state_reg == SSQ_ST_BURST);
            motor.pos   <= pos_reg;
            motor.scale <= stst_reg ? hold_reg : run_reg; // R15 R19
        end
    end

endmodule : ssq_step_dir_sequencer

`default_nettype wire

// ==== bench/ssq_step_source.sv ====
// External step/direction source driving the sequencer pins
`timescale 1ns/100ps
`default_nettype none
module ssq_step_source (
    input  wire logic clk_sys,
    output var logic  step_in,
    output var logic  dir_in
);
    initial begin
        step_in = 1'b0;
        dir_in  = 1'b0;
    end
    // Equal high and low phases, direction set a half period ahead
    task automatic pulses(input logic d, input int n, input int half);
        for (int i = 0; i < n; i++) begin
            dir_in <= d;
            repeat (half) @(posedge clk_sys);
            step_in <= 1'b1;
            repeat (half) @(posedge clk_sys);
            step_in <= 1'b0;
        end
    endtask : pulses
endmodule : ssq_step_source
`default_nettype wire

// ==== bench/ssq_sequencer_monitor.sv ====
// Port checker for the step/direction sequencer
`timescale 1ns/100ps
`default_nettype none
module ssq_sequencer_monitor #(
    parameter logic [20:0] STST_LIMIT = ssq_pkg::SSQ_STST_LIMIT
) (
    input wire logic                  clk_sys,
    input wire logic                  resetn,
    input wire logic                  step_in,
    input wire logic                  dir_in,
    input wire ssq_pkg::ssq_bus_req_t bus_req,
    input wire logic [31:0]           bus_rdata,
    input wire ssq_pkg::ssq_motor_t   motor
);
    import ssq_pkg::*;
    localparam logic [21:0] CAP = {1'b0, STST_LIMIT} + 22'h10;
    logic        step_q;
    logic [21:0] quiet;
    logic [21:0] rise_age;
    logic [3:0]  calm;
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            step_q   <= 1'b0;
            quiet    <= {1'b0, STST_LIMIT};
            rise_age <= {1'b0, STST_LIMIT};
            calm     <= 4'h0;
        end else begin
            step_q   <= step_in;
            quiet    <= (step_in != step_q) ? 22'h0 : quiet + 22'(quiet < CAP);
            rise_age <= (step_in && !step_q) ? 22'h0 : rise_age + 22'(rise_age < CAP);
            calm     <= (step_in != step_q || bus_req.wr) ? 4'h0 : calm + 4'(calm != 4'hf);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence step_rise;
        $rose(step_in) ##0 !motor.burst;
    endsequence
    sequence pos_moved;
        $changed(motor.pos) || motor.burst;
    endsequence
    pos_latency_a:
        assert property (step_rise |-> ##6 pos_moved) else $error("step edge not taken");
    pos_still_a:
        assert property (calm == 4'hf && !motor.burst && !$past(motor.burst) |-> $stable(motor.pos))
        else $error("position moved without a step");
    rdata_idle_a:
        assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0) else $error("stray read data");
    rdata_unmapped_a:
        assert property (bus_req.rd && bus_req.addr > SSQ_ADDR_INTV |=> bus_rdata == 32'h0)
        else $error("unmapped read not zero");
    stst_early_a:
        assert property ($rose(motor.stst) |-> rise_age >= {1'b0, STST_LIMIT})
        else $error("standstill set too early");
    stst_due_a:
        assert property (quiet >= CAP - 22'h4 |-> motor.stst) else $error("standstill missing");
    stst_clear_a:
        assert property ($fell(motor.stst) |-> quiet <= 22'ha) else $error("standstill cleared late");
    stst_scale_a:
        assert property ($changed(motor.stst) |-> $changed(motor.scale))
        else $error("scale did not follow standstill");
    burst_cause_a:
        assert property ($rose(motor.burst) |-> quiet <= 22'h8) else $error("burst without step");
endmodule : ssq_sequencer_monitor

bind ssq_step_dir_sequencer ssq_sequencer_monitor #(.STST_LIMIT(STST_LIMIT)) mon_u (
    .clk_sys(clk_sys), .resetn(resetn), .step_in(step_in), .dir_in(dir_in),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .motor(motor)
);
`default_nettype wire

// ==== bench/test_step_dir_microstep_sequencer.sv ====
// Self-checking bench for the step/direction sequencer
`timescale 1ns/100ps
`default_nettype none
module test_step_dir_microstep_sequencer;
    import ssq_pkg::*;
    typedef struct packed {
        logic [7:0] chop;
        logic       dir;
        logic [3:0] n;
        logic [9:0] pos;
    } ssq_row_t;
    logic         clk_sys = 1'b0;
    logic         resetn  = 1'b0;
    logic         step_in;
    logic         dir_in;
    ssq_bus_req_t req     = '0;
    logic [31:0]  bus_rdata;
    ssq_motor_t   motor;
    int           errors      = 0;
    int           comparisons = 0;
    logic [31:0]  q;
    logic [31:0]  k;
    ssq_row_t     rows [11] = '{
        '{8'h48, 1'b0, 4'd1, 10'd384}, '{8'h48, 1'b0, 4'd3, 10'd128},
        '{8'h48, 1'b1, 4'd1, 10'd896}, '{8'h47, 1'b0, 4'd1, 10'd0},
        '{8'h46, 1'b1, 4'd2, 10'd896}, '{8'h47, 1'b1, 4'd1, 10'd832},
        '{8'h46, 1'b0, 4'd0, 10'd832}, '{8'h48, 1'b0, 4'd0, 10'd896},
        '{8'h50, 1'b1, 4'd2, 10'd892}, '{8'h40, 1'b0, 4'd2, 10'd894},
        '{8'h45, 1'b0, 4'd1, 10'd912}};
    always #25 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    ssq_step_dir_sequencer #(.STST_LIMIT(21'd200)) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .step_in(step_in), .dir_in(dir_in),
        .bus_req(req), .bus_rdata(bus_rdata), .motor(motor));
    ssq_step_source src_u (.clk_sys(clk_sys), .step_in(step_in), .dir_in(dir_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("Comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic w,
                       output logic [31:0] r);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk_sys);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
        #1 r = bus_rdata;
    endtask : bus

    task automatic wait_move(output logic [31:0] cnt);
        logic [9:0] p;
        p   = motor.pos;
        cnt = 32'h0;
        while (motor.pos === p) begin
            tick(1);
            cnt++;
            if (cnt == 32'd40) begin
                errors++;
                $display("CHECK FAILED at %0t: position never moved", $time);
                stop_test();
            end
        end
    endtask : wait_move
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(3);
        check(bus_rdata, 32'h0);
        check({22'h0, motor.pos}, 32'h0);
        resetn <= 1'b1;
        bus(SSQ_ADDR_CHOP, 32'h0, 1'b0, q);
        check(q, {25'h0, SSQ_EXTSTEP_RST, SSQ_INTPOL_RST, SSQ_DEDGE_RST, SSQ_RES_RST});
        bus(SSQ_ADDR_SCALE, 32'h0, 1'b0, q);
        check(q, {19'h0, SSQ_RUN_RST, 3'h0, SSQ_HOLD_RST});
        bus(SSQ_ADDR_STAT, 32'hffff_ffff, 1'b1, q);
        bus(SSQ_ADDR_STAT, 32'h0, 1'b0, q);
        check(q, {14'h0, 1'b0, SSQ_STST_RST, 6'h0, SSQ_POS_RST});
        bus(4'hf, 32'h0, 1'b0, q);
        check(q, 32'h0);
        foreach (rows[i]) begin
            bus(SSQ_ADDR_CHOP, {24'h0, rows[i].chop}, 1'b1, q);
            src_u.pulses(rows[i].dir, int'(rows[i].n), 4);
            tick(10);
            bus(SSQ_ADDR_STAT, 32'h0, 1'b0, q);
            check({22'h0, q[9:0]}, {22'h0, rows[i].pos});
        end
        tick(220);
        check({31'h0, motor.stst}, 32'h1);
        check({27'h0, motor.scale}, {27'h0, SSQ_HOLD_RST});
        bus(SSQ_ADDR_SCALE, 32'h1503, 1'b1, q);
        tick(2);
        check({27'h0, motor.scale}, 32'h3);
        src_u.pulses(1'b0, 1, 4);
        tick(8);
        check({31'h0, motor.stst}, 32'h0);
        check({27'h0, motor.scale}, 32'h15);
        bus(SSQ_ADDR_STAT, 32'h0, 1'b0, q);
        check(q, 32'h3b0);
        bus(SSQ_ADDR_CHOP, 32'h64, 1'b1, q);
        src_u.pulses(1'b0, 4, 32);
        check({31'h0, motor.burst}, 32'h1);
        wait_move(k);
        wait_move(k);
        check(k, 32'h4);
        src_u.pulses(1'b0, 2, 8);
        tick(100);
        check({22'h0, motor.pos}, 32'h10);
        check({31'h0, motor.burst}, 32'h0);
        stop_test();
    end
endmodule : test_step_dir_microstep_sequencer
`default_nettype wire
